// file: core/flb_cur_if.sv
// carrier between the formatter and its loop cursor
// assumes both ends share clk_sys
`timescale 1ns/1ps
interface flb_cur_if #(parameter int POS_W = 6);
   logic             load;
   logic             step;
   logic [POS_W-1:0] load_pos;
   logic [POS_W-1:0] pos;

   modport ctl (output load, output step, output load_pos, input pos);
   modport cur (input load, input step, input load_pos, output pos);
endinterface : flb_cur_if

// file: core/flb_cursor.sv
// downward cursor over the cyclic telemetry loop
// assumes load and step are never raised together
`timescale 1ns/1ps
module flb_cursor
   import flb_pkg::*;
#(
   parameter int LOOP_LEN = FLB_LOOP_LEN,
   parameter int POS_W    = FLB_POS_W
) (
   input  wire logic clk_sys,
   input  wire logic rst,
   flb_cur_if.cur    cur
);

   // top of the loop; a step below position 0 lands here
   localparam logic [POS_W-1:0] POS_TOP = POS_W'(LOOP_LEN - 1);

   logic [POS_W-1:0] pos_reg;
   logic [POS_W-1:0] pos_next;

   if (LOOP_LEN < 2 || LOOP_LEN > (1 << POS_W)) begin : g_len_check
      $error("flb_cursor: loop length does not fit the position width");
   end

   // ****************************************
   // position update
   // ****************************************
   always_comb begin
      pos_next = pos_reg;
      if (cur.load) begin
         // a pointer beyond the loop would read outside it until it stepped down into range
         pos_next = (cur.load_pos > POS_TOP) ? POS_TOP : cur.load_pos;
      end else if (cur.step) begin
         pos_next = (pos_reg == '0) ? POS_TOP : pos_reg - 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pos_reg <= '0;
      end else begin
         pos_reg <= pos_next;
      end
   end

   assign cur.pos = pos_reg;

endmodule : flb_cursor

// file: core/flb_formatter.sv
// fault-log block formatter: serves the 255-byte fault record a byte at a time
// assumes the record stores answer their address in the same cycle
// How it works
// - bytes 7 to 78 are the preamble; status bytes sit at 67 to 78.
// - bytes 79 to 237 carry loop telemetry; 238 to 254 are reserved zeros.
// - byte 79 is the loop entry at the captured newest-entry pointer, or at 57 if the pointer lies beyond the loop.
// - each later loop byte is the entry one position below the previous one.
// - the loop has 58 positions, 0 to 57; the region spans about 2.7 passes.
// - the loop holds a temperature pair, then a 12-byte group per channel.
// - positions 14 to 21 are the input group, with position 17 always zero.
// - walking down returns each reading high byte first, after its status.
// - the bus counts bytes from 1, so bus byte n is block byte n minus one.
// - the record is a read-only 255-byte block, returned a byte at a time.
// - byte 0 is the pointer, bytes 1 to 6 the 41-bit stamp, low first.
`timescale 1ns/1ps
module flb_formatter
   import flb_pkg::*;
#(
   parameter int LOOP_LEN = FLB_LOOP_LEN
) (
   input  wire logic                clk_sys,
   input  wire logic                rst,
   input  wire logic                rd_start,
   input  wire logic                rd_next,
   output logic [7:0]               rd_data,
   output logic                     rd_valid,
   output logic                     rd_last,
   output logic [7:0]               bus_byte_num,
   input  wire logic [FLB_POS_W-1:0] newest_pos,
   input  wire logic [FLB_TS_W-1:0] shared_timestamp,
   output logic [6:0]               pre_addr,
   input  wire logic [7:0]          pre_data,
   output logic [FLB_POS_W-1:0]     loop_addr,
   input  wire logic [7:0]          loop_data
);

   // the zero-slot decode below is tied to the stored layout
   if (LOOP_LEN != FLB_LOOP_LEN) begin : g_len_check
      $error("flb_formatter: loop length must match the stored layout");
   end

   // ****************************************
   // state
   // ****************************************
   // stamp kept 48 bits wide so byte 6 reads as bit 40 over zero padding
   flb_state_e              state_reg,  state_next;
   logic [7:0]              idx_reg,    idx_next;
   logic [FLB_POS_W-1:0]    ptr_reg,    ptr_next;
   logic [47:0]             ts_reg,     ts_next;
   logic [7:0]              data_reg,   data_next;
   logic [7:0]              byte_sel;

   flb_cur_if #(.POS_W(FLB_POS_W)) cur_if ();

   flb_cursor #(.LOOP_LEN(LOOP_LEN), .POS_W(FLB_POS_W)) flb_cursor_inst (
      .clk_sys (clk_sys),
      .rst     (rst),
      .cur     (cur_if.cur)
   );

   // ****************************************
   // byte selection
   // ****************************************
   always_comb begin
      byte_sel = FLB_BYTE_RST;
      if (idx_reg == FLB_PTR_IDX) begin
         byte_sel = {2'h0, ptr_reg};
      end else if (idx_reg <= FLB_TS_LAST) begin
         byte_sel = ts_reg[{idx_reg[2:0] - 3'h1, 3'h0} +: 8];
      end else if (idx_reg <= FLB_PRE_LAST) begin
         byte_sel = pre_data;
      end else if (idx_reg <= FLB_LOOP_LAST) begin
         // the store is laid out by position; only the spare slot is forced
         byte_sel = (cur_if.pos == FLB_ZERO_POS) ? 8'h00
                                                 : loop_data;
      end else begin
         byte_sel = FLB_BYTE_RST;
      end
   end

   // ****************************************
   // sequencing
   // ****************************************
   always_comb begin
      // a fetch cycle per byte lets the stores answer registered addresses;
      // the price is one idle cycle between bytes
      state_next      = state_reg;
      idx_next        = idx_reg;
      ptr_next        = ptr_reg;
      ts_next         = ts_reg;
      data_next       = data_reg;
      cur_if.load     = 1'b0;
      cur_if.step     = 1'b0;
      cur_if.load_pos = newest_pos;
      if (rd_start) begin
         // a new start abandons any read in progress
         state_next  = FLB_FETCH;
         idx_next    = FLB_PTR_IDX;
         ptr_next    = newest_pos;
         ts_next     = {7'h00, shared_timestamp};
         cur_if.load = 1'b1;
      end else begin
         unique case (state_reg)
            FLB_IDLE: begin
               state_next = FLB_IDLE;
            end
            FLB_FETCH: begin
               data_next  = byte_sel;
               state_next = FLB_SERVE;
            end
            FLB_SERVE: begin
               if (rd_next) begin
                  if (idx_reg == FLB_LAST_IDX) begin
                     state_next = FLB_IDLE;
                  end else begin
                     idx_next   = idx_reg + 8'h01;
                     state_next = FLB_FETCH;
                     // downward walk gives high byte before low byte
                     cur_if.step = (idx_reg >= FLB_LOOP_FIRST);
                  end
               end
            end
            default: begin
               state_next = FLB_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_reg <= FLB_IDLE;
         idx_reg   <= 8'h00;
         ptr_reg   <= '0;
         ts_reg    <= 48'h0;
         data_reg  <= FLB_BYTE_RST;
      end else begin
         state_reg <= state_next;
         idx_reg   <= idx_next;
         ptr_reg   <= ptr_next;
         ts_reg    <= ts_next;
         data_reg  <= data_next;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign rd_data      = data_reg;
   assign rd_valid     = (state_reg == FLB_SERVE);
   assign rd_last      = rd_valid && (idx_reg == FLB_LAST_IDX);
   assign bus_byte_num = idx_reg + FLB_BUS_BASE;
   assign pre_addr     = idx_reg[6:0];
   assign loop_addr    = cur_if.pos;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_preamble_src: assert property (
      rd_valid && idx_reg >= FLB_PRE_FIRST && idx_reg <= FLB_PRE_LAST
      |-> rd_data == $past(pre_data) && $past(pre_addr) == idx_reg[6:0])
      else $error("preamble byte not taken from the preamble store");

   a_reserved_zero: assert property (
      rd_valid && idx_reg >= FLB_RSV_FIRST |-> rd_data == 8'h00)
      else $error("reserved byte is not zero");

   a_first_loop: assert property (
      rd_valid && idx_reg == FLB_LOOP_FIRST
      |-> $past(loop_addr) == ptr_reg || ptr_reg > 6'h39)
      else $error("first loop byte not at the newest pointer");

   a_loop_step: assert property (
      rd_valid && rd_next && !rd_start && idx_reg >= FLB_LOOP_FIRST
      && idx_reg < FLB_LOOP_LAST
      |=> loop_addr == (($past(loop_addr) == 6'h00) ? 6'h39
                        : $past(loop_addr) - 6'h01) ##1 rd_valid)
      else $error("loop position did not step down by one");

   a_pos_range: assert property (
      loop_addr <= 6'h39)
      else $error("loop position outside the loop");

   a_spare_zero: assert property (
      rd_valid && idx_reg >= FLB_LOOP_FIRST && idx_reg <= FLB_LOOP_LAST
      && $past(loop_addr) == FLB_ZERO_POS |-> rd_data == 8'h00)
      else $error("spare loop slot is not zero");

   a_bus_count: assert property (
      rd_valid |-> bus_byte_num == idx_reg + 8'h01)
      else $error("bus byte number is not block index plus one");

   a_block_end: assert property (
      rd_last && rd_next && !rd_start |=> !rd_valid [*2])
      else $error("block did not end after byte 254");

   a_pointer_byte: assert property (
      rd_start ##2 !$past(rd_start) |-> rd_valid
      && rd_data == {2'h0, $past(newest_pos, 2)})
      else $error("byte 0 does not carry the captured pointer");

   a_stamp_take: assert property (
      rd_start |=> ts_reg[FLB_TS_W-1:0] == $past(shared_timestamp))
      else $error("timestamp not captured at the start of a read");

   a_stamp_top: assert property (
      rd_valid && idx_reg == FLB_TS_LAST |-> rd_data[7:1] == 7'h00)
      else $error("timestamp top byte carries bits above bit 40");

   c_full_block: cover property (rd_last && rd_next);
   c_loop_wrap: cover property (
      rd_valid && loop_addr == 6'h00 ##[1:3] loop_addr == 6'h39);
   c_restart: cover property (rd_valid && rd_start);
   c_spare_slot: cover property (
      rd_valid && idx_reg >= FLB_LOOP_FIRST && idx_reg <= FLB_LOOP_LAST
      && $past(loop_addr) == FLB_ZERO_POS);
   c_held_next: cover property (
      rd_valid && rd_next ##1 !rd_valid && rd_next);

endmodule : flb_formatter

// file: core/flb_pkg.sv
// constants shared by the fault-log block formatter and its loop cursor
// assumes one system clock and an active-high asynchronous reset
package flb_pkg;

   // ****************************************
   // block layout
   // ****************************************
   localparam int          FLB_BLOCK_LEN  = 255;
   localparam logic [7:0]  FLB_LAST_IDX   = 8'hfe;
   localparam logic [7:0]  FLB_PTR_IDX    = 8'h00;
   localparam logic [7:0]  FLB_TS_FIRST   = 8'h01;
   localparam logic [7:0]  FLB_TS_LAST    = 8'h06;
   localparam logic [7:0]  FLB_PRE_FIRST  = 8'h07;
   localparam logic [7:0]  FLB_STAT_FIRST = 8'h43;
   localparam logic [7:0]  FLB_PRE_LAST   = 8'h4e;
   localparam logic [7:0]  FLB_LOOP_FIRST = 8'h4f;
   localparam logic [7:0]  FLB_LOOP_LAST  = 8'hed;
   localparam logic [7:0]  FLB_RSV_FIRST  = 8'hee;
   localparam logic [7:0]  FLB_BUS_BASE   = 8'h01;

   // ****************************************
   // cyclic telemetry loop
   // ****************************************
   localparam int          FLB_LOOP_LEN   = 58;
   localparam int          FLB_POS_W      = 6;
   localparam logic [5:0]  FLB_ZERO_POS   = 6'h11;

   // ****************************************
   // timestamp and reset values
   // ****************************************
   localparam int          FLB_TS_W       = 41;
   localparam logic [7:0]  FLB_BYTE_RST   = 8'h00;

   typedef enum logic [2:0] {
      FLB_IDLE  = 3'b001,
      FLB_FETCH = 3'b010,
      FLB_SERVE = 3'b100
   } flb_state_e;

endpackage : flb_pkg

// file: dv/flb_store_model.sv
// record-store model: preamble and loop stores behind the formatter
// assumes combinational reads; contents are a fixed function of address
`timescale 1ns/1ps
module flb_store_model
   import flb_pkg::*;
(
   input  wire logic [6:0]           pre_addr,
   output logic      [7:0]           pre_data,
   input  wire logic [FLB_POS_W-1:0] loop_addr,
   output logic      [7:0]           loop_data
);
   // ****************************************
   // store contents
   // ****************************************
   // every byte differs from its neighbours so a slip in order shows up
   assign pre_data  = {1'b1, pre_addr} ^ 8'h3c;
   // position 17 holds a non-zero byte here: the formatter must mask it
   assign loop_data = {2'b11, loop_addr};
endmodule : flb_store_model

// file: dv/test_fault_log_block_formatter.sv
// bench for the fault-log block formatter: full, wrapped, restarted reads
// assumes the store model answers both stores in the same cycle
`timescale 1ns/1ps
module test_fault_log_block_formatter
   import flb_pkg::*;
;
   logic                 clk_sys;
   logic                 rst;
   logic                 rd_start;
   logic                 rd_next;
   logic [7:0]           rd_data;
   logic                 rd_valid;
   logic                 rd_last;
   logic [7:0]           bus_byte_num;
   logic [FLB_POS_W-1:0] newest_pos;
   logic [FLB_TS_W-1:0]  shared_timestamp;
   logic [6:0]           pre_addr;
   logic [7:0]           pre_data;
   logic [FLB_POS_W-1:0] loop_addr;
   logic [7:0]           loop_data;
   int                   failures;
   int                   samples_checked;

   flb_formatter #(.LOOP_LEN(FLB_LOOP_LEN)) flb_formatter_inst (
      .clk_sys(clk_sys), .rst(rst), .rd_start(rd_start), .rd_next(rd_next),
      .rd_data(rd_data), .rd_valid(rd_valid), .rd_last(rd_last),
      .bus_byte_num(bus_byte_num), .newest_pos(newest_pos),
      .shared_timestamp(shared_timestamp), .pre_addr(pre_addr),
      .pre_data(pre_data), .loop_addr(loop_addr), .loop_data(loop_data));

   flb_store_model flb_store_model_inst (
      .pre_addr(pre_addr), .pre_data(pre_data),
      .loop_addr(loop_addr), .loop_data(loop_data));

   // ****************************************
   // checking helpers
   // ****************************************
   function automatic logic [7:0] exp_byte(input int idx,
                                           input logic [5:0] ptr,
                                           input logic [40:0] ts);
      int          pos;
      logic [40:0] sh;
      if (idx == 0) return {2'b00, ptr};
      sh = ts >> (8 * (idx - 1));
      if (idx <= 6) return sh[7:0];
      if (idx <= 78) return {1'b1, 7'(idx)} ^ 8'h3c;
      if (idx > 237) return 8'h00;
      pos = (int'(ptr) - (idx - 79)) % 58;
      if (pos < 0) pos += 58;
      if (pos == 17) return 8'h00;
      return {2'b11, 6'(pos)};
   endfunction : exp_byte

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk8

   task automatic close_out;
      $display("failures=%0d samples_checked=%0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out

   // bounded wait; counts edges after the caller's last edge, so the
   // request edge itself has already passed
   task automatic wait_valid(input int n_exp);
      int n;
      n = 0;
      while (rd_valid !== 1'b1 && n < 8) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk8(8'(n), 8'(n_exp));
   endtask : wait_valid

   // hold keeps rd_next up through the gap cycle, where it must be ignored
   task automatic next_byte(input bit hold);
      rd_next = 1'b1;
      @(posedge clk_sys);
      #1;
      if (hold) begin
         @(posedge clk_sys);
         #1;
      end
      rd_next = 1'b0;
   endtask : next_byte

   // ****************************************
   // scenarios
   // ****************************************
   task automatic read_block(input logic [5:0] ptr, input logic [40:0] ts,
                             input int nbytes, input bit hold);
      logic [7:0] exp_b;
      @(posedge clk_sys);
      #1;
      newest_pos = ptr;
      shared_timestamp = ts;
      rd_start = 1'b1;
      @(posedge clk_sys);
      #1;
      rd_start = 1'b0;
      // inputs move on at once: the block must use what was captured
      newest_pos = ~ptr;
      shared_timestamp = ~ts;
      // byte 0 stands two edges after the start edge, one of them gone
      wait_valid(1);
      for (int i = 0; i < nbytes; i++) begin
         // a held rd_next has already spent the gap edge in next_byte
         if (i > 0) wait_valid(hold ? 0 : 1);
         exp_b = exp_byte(i, ptr, ts);
         chk8(rd_data, exp_b);
         chk8(bus_byte_num, 8'(i + 1));
         chk8({7'h00, rd_last}, {7'h00, i == 254});
         if (i < nbytes - 1 || nbytes == 255) next_byte(hold);
      end
   endtask : read_block

   task automatic check_end;
      repeat (4) begin
         chk8({7'h00, rd_valid}, 8'h00);
         next_byte(1'b0);
      end
   endtask : check_end

   task automatic mid_reset;
      read_block(6'h20, 41'h0aa55aa55aa, 10, 1'b0);
      rst = 1'b1;
      @(posedge clk_sys);
      #1;
      chk8({7'h00, rd_valid}, 8'h00);
      chk8(bus_byte_num, 8'h01);
      chk8(rd_data, 8'h00);
      chk8({2'b00, loop_addr}, 8'h00);
      rst = 1'b0;
   endtask : mid_reset

   // ****************************************
   // clock, main sequence, watchdog
   // ****************************************
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   initial begin
      rst = 1'b1;
      rd_start = 1'b0;
      rd_next = 1'b0;
      newest_pos = '0;
      shared_timestamp = '0;
      failures = 0;
      samples_checked = 0;
      repeat (3) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      read_block(6'd13, 41'h1abcdef0123, 255, 1'b1);
      check_end;
      read_block(6'd0, 41'h0123456789a, 255, 1'b0);
      check_end;
      read_block(6'd5, 41'h00000000001, 120, 1'b0);
      read_block(6'd57, 41'h10000000000, 255, 1'b0);
      check_end;
      mid_reset;
      read_block(6'd17, 41'h1ffffffffff, 100, 1'b0);
      close_out;
   end

   // a full read takes about 512 cycles; this allows about ten times the whole run of about 2000 cycles
   initial begin
      #(20000 * 4);
      failures++;
      close_out;
   end
endmodule : test_fault_log_block_formatter
